// ==== rtl/timer_pkg.sv ====
// Contract
// R1 - Shared channel four/five requests interrupt when enabled and flagged.
// R2 - Compare channels 1..4 request interrupt when enabled and flagged.
// R3 - Capture channels 1..3 request interrupt when enabled and flagged.
// R4 - Counter overflow requests interrupt when enabled and flagged.
// R5 - Accumulator overflow requests interrupt when enabled and flagged.
// R6 - Accumulator input requests interrupt when enabled and flagged.
// R7 - Compare clock output enable puts main counter clock on compare one.
// R8 - Main clock select: system clock divided 4..256, code 111 external pin.
// R9 - A flag with its enable cleared produces no request.
// R10 - Shared flag sets on compare five match or shared pin edge.
// R11 - Compare flag sets whenever main counter equals that channel's value.
// R12 - Capture flag sets on the configured edge at its pin.
// R13 - Overflow flag sets when main counter wraps from all ones to zero.
// R14 - Accumulator overflow flag sets when 8-bit accumulator wraps to zero.
// R15 - Accumulator input flag: active edge in event mode, gate end in gated.
// R16 - Force-compare write of 1 performs pin action without setting the flag.
// R17 - Force enable A drives force level A, overriding PWM and clock output.
// R18 - Force enable B drives force level B instead of the PWM wave.
// R19 - PWM clock output with A force off drives main counter clock on A.
// R20 - PWM clock select: system clock divided 2..128, code 111 external pin.
// R21 - PWM A period is 256 increments, or 32768 when slow selected.
// R22 - PWM B period is 256 increments, or 32768 when slow selected.
// R23 - Force level 1 drives high, 0 drives low while forcing.
// R24 - Shared select 1 makes capture four, 0 makes compare five.
// R25 - Duty 0x00 stays low, 0x80 half high, 0xff high 255 of 256.
// R26 - Flags stay set until software clears them, withdrawing the request.
package timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRESCALE_W = 9;
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_FORCE = 8'h08;
  localparam logic [7:0] OFS_ACCUM_CTL = 8'h0c;
  localparam logic [7:0] OFS_CMP_MODE = 8'h10;
  localparam logic [7:0] OFS_CAP_EDGE = 8'h14;
  localparam logic [7:0] OFS_MAIN_CNT = 8'h18;
  localparam logic [7:0] OFS_CMP_BASE = 8'h1c;
  localparam logic [7:0] OFS_CMP_LAST = 8'h2c;
  localparam logic [7:0] OFS_PWM_DUTY = 8'h30;
  localparam logic [7:0] OFS_PWM_CNT = 8'h34;
  localparam logic [7:0] OFS_ACCUM_CNT = 8'h38;
  // Flag and mask register layout
  localparam int F_SHARED = 15;
  localparam int F_CMP_LO = 11;
  localparam int F_CAP_LO = 8;
  localparam int F_OVF = 7;
  localparam int F_AOVF = 5;
  localparam int F_AIN = 4;
  localparam int M_CLK_OUT = 3;
  localparam int M_CSEL_LO = 0;
  localparam logic [15:0] FLAG_BITS = 16'hffb0;
  localparam logic [15:0] MASK_BITS = 16'hffbf;
  // Force / PWM control layout
  localparam int C_FORCE_LO = 11;
  localparam int C_FEN_A = 10;
  localparam int C_FEN_B = 9;
  localparam int C_PCLK_OUT = 8;
  localparam int C_PSEL_LO = 4;
  localparam int C_SLOW_A = 3;
  localparam int C_SLOW_B = 2;
  localparam int C_FLVL_A = 1;
  localparam int C_FLVL_B = 0;
  localparam logic [15:0] CTRL_BITS = 16'h077f;
  // Accumulator control layout
  localparam int A_SEL = 6;
  localparam int A_EN = 5;
  localparam int A_MODE = 4;
  localparam int A_EDGE = 3;
  localparam int A_CLK_LO = 0;
  localparam logic [15:0] ACC_BITS = 16'h007b;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [7:0] ACC_TOP = 8'hff;
  localparam logic [2:0] SEL_EXT = 3'h7;
  localparam int SLOW_SHIFT = 7;
  typedef enum logic [1:0] {
    ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET
  } cmp_action_t;
endpackage

// ==== rtl/pwm_cfg_if.sv ====
`timescale 1ns/1ps
interface pwm_cfg_if;
  logic [15:0] count;
  logic [7:0] duty;
  logic slow;
  logic force_en;
  logic force_level;
  logic clk_out_en;
  logic clk_level;
  modport source(output count, duty, slow, force_en, force_level,
    clk_out_en, clk_level);
  modport sink(input count, duty, slow, force_en, force_level,
    clk_out_en, clk_level);
endinterface

// ==== rtl/prescaler_taps.sv ====
`timescale 1ns/1ps
module prescaler_taps #(
  parameter int WIDTH = 9
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic [WIDTH-1:0] tick
);
  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + WIDTH'(1);
    end
  end

  // Tap k pulses once every 2^(k+1) system clocks
  for (genvar k = 0; k < WIDTH; k++) begin : g_tap
    assign tick[k] = &count_reg[k:0];
  end
endmodule // prescaler_taps

// ==== rtl/pwm_channel.sv ====
`timescale 1ns/1ps
module pwm_channel (
  input wire logic core_clk,
  input wire logic nrst,
  pwm_cfg_if.sink cfg,
  output logic pin
);
  logic [7:0] phase;
  logic wave;

  // Slow period takes the upper byte of a 15-bit span
  assign phase = cfg.slow ? cfg.count[timer_pkg::SLOW_SHIFT +: 8]
                          : cfg.count[7:0]; // R21 R22
  assign wave = phase < cfg.duty; // R25

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin <= 1'b0;
    end else if (cfg.force_en) begin
      pin <= cfg.force_level; // R17 R18 R23
    end else if (cfg.clk_out_en) begin
      pin <= cfg.clk_level; // R19
    end else begin
      pin <= wave;
    end
  end
endmodule // pwm_channel

// ==== rtl/timer_irq_flags_pwm_control.sv ====
`timescale 1ns/1ps
module timer_irq_flags_pwm_control (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  input wire logic [2:0] capture_pins,
  input wire logic shared_pin_in,
  input wire logic accum_input_pin,
  input wire logic ext_clock_pin,
  output logic [4:0] compare_pins,
  output logic shared_pin_oe,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic irq_req
);
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic [5:0] pin_prev_reg;
  logic [15:0] mask_reg;
  logic [15:0] flags_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] accum_ctl_reg;
  logic [9:0] cmp_mode_reg;
  logic [7:0] cap_edge_reg;
  logic [15:0] main_cnt_reg;
  logic [15:0] cmp_val_reg [5];
  logic [7:0] duty_a_reg;
  logic [7:0] duty_b_reg;
  logic [15:0] pwm_cnt_reg;
  logic [7:0] accum_cnt_reg;
  logic cnt_moved_reg;
  logic main_clk_reg;
  logic gate_open_reg;
  logic [4:0] cmp_pin_reg;
  logic [15:0] rd_next;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [timer_pkg::PRESCALE_W-1:0] pre_tick;
  logic ext_rise;
  logic main_tick;
  logic pwm_tick;
  logic gated_clk;
  logic ovf_ev;
  logic [4:0] cmp_hit;
  logic [3:0] cap_hit;
  logic [4:0] force_cmp;
  logic shared_sel;
  logic acc_en;
  logic acc_mode;
  logic acc_edge;
  logic active_edge;
  logic gate_open;
  logic acc_inc;
  logic aovf_ev;
  logic ain_ev;
  logic [2:0] csel;
  logic [2:0] psel;
  logic [3:0] cap_cur;
  logic [3:0] cap_old;
  logic acc_cur;
  logic acc_old;

  pwm_cfg_if cfg_a ();
  pwm_cfg_if cfg_b ();

  prescaler_taps #(
    .WIDTH(timer_pkg::PRESCALE_W)
  ) u_prescaler (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(pre_tick)
  );

  pwm_channel u_pwm_a (
    .core_clk(core_clk),
    .nrst(nrst),
    .cfg(cfg_a.sink),
    .pin(pwm_out_a)
  );

  pwm_channel u_pwm_b (
    .core_clk(core_clk),
    .nrst(nrst),
    .cfg(cfg_b.sink),
    .pin(pwm_out_b)
  );

  // Pin order: ext clock, accumulator, shared, capture 3..1
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= {ext_clock_pin, accum_input_pin, shared_pin_in,
                       capture_pins};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign ext_rise = pin_sync_reg[5] & ~pin_prev_reg[5];
  assign acc_cur = pin_sync_reg[4];
  assign acc_old = pin_prev_reg[4];
  assign cap_cur = pin_sync_reg[3:0];
  assign cap_old = pin_prev_reg[3:0];

  assign csel = mask_reg[timer_pkg::M_CSEL_LO +: 3];
  assign psel = ctrl_reg[timer_pkg::C_PSEL_LO +: 3];
  assign shared_sel = accum_ctl_reg[timer_pkg::A_SEL];
  assign acc_en = accum_ctl_reg[timer_pkg::A_EN];
  assign acc_mode = accum_ctl_reg[timer_pkg::A_MODE];
  assign acc_edge = accum_ctl_reg[timer_pkg::A_EDGE];

  // Divide-by-4 sits on tap 1, each code doubles it
  assign main_tick = (csel == timer_pkg::SEL_EXT) ? ext_rise
                   : pre_tick[csel + 3'h1]; // R8
  assign pwm_tick = (psel == timer_pkg::SEL_EXT) ? ext_rise
                  : pre_tick[psel]; // R20

  assign ovf_ev = main_tick && (main_cnt_reg == timer_pkg::CNT_TOP); // R13

  // Compare sees the counter one cycle after it moved
  for (genvar i = 0; i < 5; i++) begin : g_cmp
    assign cmp_hit[i] = cnt_moved_reg
                        && (main_cnt_reg == cmp_val_reg[i]); // R11
    assign force_cmp[i] = wr_stb && (addr == timer_pkg::OFS_FORCE)
                          && wr_data[timer_pkg::C_FORCE_LO + i]; // R16
  end

  for (genvar i = 0; i < 4; i++) begin : g_cap
    logic [1:0] edge_cfg;
    assign edge_cfg = cap_edge_reg[2*i +: 2];
    assign cap_hit[i] = (edge_cfg[0] & cap_cur[i] & ~cap_old[i])
                      | (edge_cfg[1] & ~cap_cur[i] & cap_old[i]); // R12
  end

  // Edge bit picks rising when set; in gated mode it names the blocking level
  assign active_edge = acc_edge ? (acc_cur & ~acc_old)
                                : (~acc_cur & acc_old);
  assign gate_open = acc_cur ^ acc_edge;

  always_comb begin
    unique case (accum_ctl_reg[timer_pkg::A_CLK_LO +: 2])
      2'h0: gated_clk = pre_tick[timer_pkg::PRESCALE_W-1];
      2'h1: gated_clk = main_tick;
      2'h2: gated_clk = ovf_ev;
      2'h3: gated_clk = ext_rise;
    endcase
  end

  assign acc_inc = acc_en && (acc_mode ? (gate_open && gated_clk)
                                       : active_edge);
  assign aovf_ev = acc_inc && (accum_cnt_reg == timer_pkg::ACC_TOP); // R14
  assign ain_ev = acc_en && (acc_mode ? (gate_open_reg && !gate_open)
                                      : active_edge); // R15

  always_comb begin
    flag_set = '0;
    flag_set[timer_pkg::F_SHARED] = shared_sel ? cap_hit[3]
                                               : cmp_hit[4]; // R10 R24
    flag_set[timer_pkg::F_CMP_LO +: 4] = cmp_hit[3:0]; // R11
    flag_set[timer_pkg::F_CAP_LO +: 3] = cap_hit[2:0]; // R12
    flag_set[timer_pkg::F_OVF] = ovf_ev;
    flag_set[timer_pkg::F_AOVF] = aovf_ev;
    flag_set[timer_pkg::F_AIN] = ain_ev;
  end

  assign flag_clr = (wr_stb && addr == timer_pkg::OFS_FLAGS)
                    ? (wr_data & timer_pkg::FLAG_BITS) : '0;

  // A set in the clearing cycle survives
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= timer_pkg::RESET_ZERO;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set; // R26
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |(flags_reg & mask_reg
                   & timer_pkg::FLAG_BITS); // R1 R2 R3 R4 R5 R6 R9 R26
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= timer_pkg::RESET_ZERO;
      ctrl_reg <= timer_pkg::RESET_ZERO;
      accum_ctl_reg <= timer_pkg::RESET_ZERO;
      cmp_mode_reg <= '0;
      cap_edge_reg <= '0;
      duty_a_reg <= '0;
      duty_b_reg <= '0;
    end else if (wr_stb) begin
      unique case (addr)
        timer_pkg::OFS_MASK: mask_reg <= wr_data & timer_pkg::MASK_BITS;
        timer_pkg::OFS_FORCE: ctrl_reg <= wr_data & timer_pkg::CTRL_BITS;
        timer_pkg::OFS_ACCUM_CTL: begin
          accum_ctl_reg <= wr_data & timer_pkg::ACC_BITS;
        end
        timer_pkg::OFS_CMP_MODE: cmp_mode_reg <= wr_data[9:0];
        timer_pkg::OFS_CAP_EDGE: cap_edge_reg <= wr_data[7:0];
        timer_pkg::OFS_PWM_DUTY: begin
          duty_a_reg <= wr_data[15:8];
          duty_b_reg <= wr_data[7:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 5; i++) begin
        cmp_val_reg[i] <= timer_pkg::CMP_RESET;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_stb && addr == timer_pkg::OFS_CMP_BASE + 8'(4 * i)) begin
          cmp_val_reg[i] <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      main_cnt_reg <= '0;
      cnt_moved_reg <= 1'b0;
      main_clk_reg <= 1'b0;
    end else begin
      cnt_moved_reg <= main_tick;
      if (main_tick) begin
        main_cnt_reg <= main_cnt_reg + 16'h0001;
        main_clk_reg <= ~main_clk_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt_reg <= '0;
    end else if (pwm_tick) begin
      pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accum_cnt_reg <= '0;
      gate_open_reg <= 1'b0;
    end else begin
      gate_open_reg <= gate_open;
      if (acc_inc) begin
        accum_cnt_reg <= accum_cnt_reg + 8'h01;
      end
    end
  end

  // Match and force both apply the programmed action; only a match flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_pin_reg <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if ((cmp_hit[i] || force_cmp[i]) && !(i == 4 && shared_sel)) begin
          unique case (timer_pkg::cmp_action_t'(cmp_mode_reg[2*i +: 2]))
            timer_pkg::ACT_NONE: ;
            timer_pkg::ACT_TOGGLE: cmp_pin_reg[i] <= ~cmp_pin_reg[i];
            timer_pkg::ACT_CLEAR: cmp_pin_reg[i] <= 1'b0;
            timer_pkg::ACT_SET: cmp_pin_reg[i] <= 1'b1;
          endcase // R16
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      compare_pins <= '0;
      shared_pin_oe <= 1'b0;
    end else begin
      compare_pins[4:1] <= cmp_pin_reg[4:1];
      compare_pins[0] <= mask_reg[timer_pkg::M_CLK_OUT] ? main_clk_reg
                                                        : cmp_pin_reg[0]; // R7
      shared_pin_oe <= !shared_sel; // R24
    end
  end

  assign cfg_a.count = pwm_cnt_reg;
  assign cfg_a.duty = duty_a_reg;
  assign cfg_a.slow = ctrl_reg[timer_pkg::C_SLOW_A]; // R21
  assign cfg_a.force_en = ctrl_reg[timer_pkg::C_FEN_A]; // R17
  assign cfg_a.force_level = ctrl_reg[timer_pkg::C_FLVL_A]; // R23
  assign cfg_a.clk_out_en = ctrl_reg[timer_pkg::C_PCLK_OUT]; // R19
  assign cfg_a.clk_level = main_clk_reg;
  assign cfg_b.count = pwm_cnt_reg;
  assign cfg_b.duty = duty_b_reg;
  assign cfg_b.slow = ctrl_reg[timer_pkg::C_SLOW_B]; // R22
  assign cfg_b.force_en = ctrl_reg[timer_pkg::C_FEN_B]; // R18
  assign cfg_b.force_level = ctrl_reg[timer_pkg::C_FLVL_B]; // R23
  assign cfg_b.clk_out_en = 1'b0;
  assign cfg_b.clk_level = 1'b0;

  always_comb begin
    rd_next = '0;
    if (addr >= timer_pkg::OFS_CMP_BASE && addr <= timer_pkg::OFS_CMP_LAST
        && addr[1:0] == 2'h0) begin
      rd_next = cmp_val_reg[3'((addr - timer_pkg::OFS_CMP_BASE) >> 2)];
    end else begin
      unique case (addr)
        timer_pkg::OFS_MASK: rd_next = mask_reg;
        timer_pkg::OFS_FLAGS: rd_next = flags_reg;
        timer_pkg::OFS_FORCE: rd_next = ctrl_reg;
        timer_pkg::OFS_ACCUM_CTL: rd_next = accum_ctl_reg;
        timer_pkg::OFS_CMP_MODE: rd_next = {6'h00, cmp_mode_reg};
        timer_pkg::OFS_CAP_EDGE: rd_next = {8'h00, cap_edge_reg};
        timer_pkg::OFS_MAIN_CNT: rd_next = main_cnt_reg;
        timer_pkg::OFS_PWM_DUTY: rd_next = {duty_a_reg, duty_b_reg};
        timer_pkg::OFS_PWM_CNT: rd_next = pwm_cnt_reg;
        timer_pkg::OFS_ACCUM_CNT: rd_next = {8'h00, accum_cnt_reg};
        default: rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_stb ? rd_next : 16'h0000;
    end
  end
endmodule // timer_irq_flags_pwm_control

// ==== bench/timer_ctl_checker.sv ====
`timescale 1ns/1ps
module timer_ctl_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic shared_pin_oe,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic irq_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  rd_idle_a: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  mask_off_a: assert property ((wr_stb && !rd_stb
    && addr == timer_pkg::OFS_MASK && wr_data[15:4] == 12'h000)
    |-> ##2 !irq_req)
    else $error("request while all enables are off");
  force_a_a: assert property ((wr_stb
    && addr == timer_pkg::OFS_FORCE && wr_data[timer_pkg::C_FEN_A])
    |-> ##2 pwm_out_a == $past(wr_data[timer_pkg::C_FLVL_A], 2))
    else $error("output a ignores its forced level");
  force_b_a: assert property ((wr_stb
    && addr == timer_pkg::OFS_FORCE && wr_data[timer_pkg::C_FEN_B])
    |-> ##2 pwm_out_b == $past(wr_data[timer_pkg::C_FLVL_B], 2))
    else $error("output b ignores its forced level");
  flag_spare_a: assert property ($past(rd_stb && addr == timer_pkg::OFS_FLAGS)
    |-> (rd_data & ~timer_pkg::FLAG_BITS) == 16'h0000)
    else $error("unused flag bits read non-zero");
  force_read_a: assert property ($past(rd_stb
    && addr == timer_pkg::OFS_FORCE) |-> rd_data[15:11] == 5'h00)
    else $error("force bits read non-zero");
  unmapped_zero_a: assert property ($past(rd_stb && addr > 8'h38)
    |-> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(nrst) == 1'b0
    |-> !irq_req && !pwm_out_a && !pwm_out_b && !shared_pin_oe)
    else $error("outputs active right after reset");
endmodule // timer_ctl_checker

// ==== bench/pin_partner.sv ====
`timescale 1ns/1ps
module pin_partner (
  input wire logic core_clk,
  input wire logic [4:0] compare_pins,
  input wire logic shared_pin_oe,
  output logic [2:0] capture_pins,
  output logic shared_pin_in,
  output logic accum_input_pin,
  output logic ext_clock_pin
);
  // Lines 0..2 capture, 3 shared, 4 accumulator input, 5 count clock
  logic [5:0] drv = 6'h00;
  assign capture_pins = drv[2:0];
  // Shared wire follows the device whenever it drives the pin
  assign shared_pin_in = shared_pin_oe ? compare_pins[4] : drv[3];
  assign accum_input_pin = drv[4];
  // Count clock stands low outside pulses
  assign ext_clock_pin = drv[5];
  task automatic pulse(input int ch);
    @(posedge core_clk);
    drv[ch] <= 1'b1;
    repeat (6) @(posedge core_clk);
    drv[ch] <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
endmodule // pin_partner

// ==== bench/test_timer_irq_flags_pwm_control.sv ====
`timescale 1ns/1ps
module test_timer_irq_flags_pwm_control;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rd_data;
  logic [2:0] capture_pins;
  logic shared_pin_in, accum_input_pin, ext_clock_pin;
  logic [4:0] compare_pins;
  logic shared_pin_oe, pwm_out_a, pwm_out_b, irq_req;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int ha, hb;
  logic [15:0] v, c;

  always #4 core_clk = ~core_clk;

  timer_irq_flags_pwm_control timer_irq_flags_pwm_control_inst (
    .core_clk, .nrst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .capture_pins, .shared_pin_in, .accum_input_pin, .ext_clock_pin,
    .compare_pins, .shared_pin_oe, .pwm_out_a, .pwm_out_b, .irq_req);
  pin_partner pin_partner_inst (
    .core_clk, .compare_pins, .shared_pin_oe, .capture_pins,
    .shared_pin_in, .accum_input_pin, .ext_clock_pin);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, irq_req}, {15'h0000, exp});
  endtask
  // Counts high cycles of both outputs over two fast periods
  task automatic count_high(output int na, output int nb);
    na = 0;
    nb = 0;
    repeat (1024) begin
      @(negedge core_clk);
      na += pwm_out_a;
      nb += pwm_out_b;
    end
  endtask
  task automatic final_report;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(timer_pkg::OFS_MASK, 16'h0000);
    rchk(timer_pkg::OFS_FLAGS, 16'h0000);
    rchk(timer_pkg::OFS_FORCE, 16'h0000);
    rchk(timer_pkg::OFS_CMP_BASE, timer_pkg::CMP_RESET);
    rchk(8'h3c, 16'h0000);
    wr(timer_pkg::OFS_MASK, 16'hffff);
    rchk(timer_pkg::OFS_MASK, 16'hffbf);
    wr(timer_pkg::OFS_MASK, 16'h0000);
    irq_chk(1'b0);
    // Compare values placed ahead of the running counter
    rd(timer_pkg::OFS_MAIN_CNT, c);
    for (int n = 1; n <= 5; n++) begin
      wr(timer_pkg::OFS_CMP_BASE + 8'(4 * (n - 1)), c + 16'(32 * n));
    end
    repeat (800) @(posedge core_clk);
    rchk(timer_pkg::OFS_FLAGS, 16'hf800);
    chk({15'h0000, shared_pin_oe}, 16'h0001);
    wr(timer_pkg::OFS_MASK, 16'h0800);
    irq_chk(1'b1);
    wr(timer_pkg::OFS_MASK, 16'h8000);
    irq_chk(1'b1);
    wr(timer_pkg::OFS_FLAGS, 16'hffff);
    irq_chk(1'b0);
    // Capture edges on each input
    wr(timer_pkg::OFS_CAP_EDGE, 16'h0055);
    wr(timer_pkg::OFS_MASK, 16'h0000);
    v = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      pin_partner_inst.pulse(i);
      v[timer_pkg::F_CAP_LO + i] = 1'b1;
      rchk(timer_pkg::OFS_FLAGS, v);
    end
    irq_chk(1'b0);
    wr(timer_pkg::OFS_MASK, 16'h0700);
    irq_chk(1'b1);
    wr(timer_pkg::OFS_FLAGS, 16'hffff);
    irq_chk(1'b0);
    // Shared channel as capture, accumulator counting rising edges
    wr(timer_pkg::OFS_ACCUM_CTL, 16'h0068);
    pin_partner_inst.pulse(3);
    pin_partner_inst.pulse(4);
    rchk(timer_pkg::OFS_FLAGS, 16'h8010);
    chk({15'h0000, shared_pin_oe}, 16'h0000);
    wr(timer_pkg::OFS_MASK, 16'h8000);
    irq_chk(1'b1);
    wr(timer_pkg::OFS_MASK, 16'h0010);
    irq_chk(1'b1);
    wr(timer_pkg::OFS_FLAGS, 16'hffff);
    repeat (254) pin_partner_inst.pulse(4);
    rchk(timer_pkg::OFS_FLAGS, 16'h0010);
    pin_partner_inst.pulse(4);
    rchk(timer_pkg::OFS_FLAGS, 16'h0030);
    wr(timer_pkg::OFS_MASK, 16'h0020);
    irq_chk(1'b1);
    // Gated mode: flag when the gate closes again
    wr(timer_pkg::OFS_ACCUM_CTL, 16'h0070);
    wr(timer_pkg::OFS_FLAGS, 16'hffff);
    pin_partner_inst.pulse(4);
    rchk(timer_pkg::OFS_FLAGS, 16'h0010);
    // Forced toggle on compare two leaves its flag clear
    wr(timer_pkg::OFS_MASK, 16'h0000);
    wr(timer_pkg::OFS_FLAGS, 16'hffff);
    wr(timer_pkg::OFS_CMP_MODE, 16'h0004);
    #1 v[0] = compare_pins[1];
    wr(timer_pkg::OFS_FORCE, 16'h1000);
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0000, compare_pins[1]}, {15'h0000, ~v[0]});
    rchk(timer_pkg::OFS_FLAGS, 16'h0000);
    rchk(timer_pkg::OFS_FORCE, 16'h0000);
    // Duty at half and at maximum, fast period, divide by two
    wr(timer_pkg::OFS_PWM_DUTY, 16'h80ff);
    repeat (600) @(posedge core_clk);
    count_high(ha, hb);
    chk(16'(ha), 16'h0200);
    chk(16'(hb), 16'h03fc);
    for (int l = 0; l < 2; l++) begin
      wr(timer_pkg::OFS_FORCE, 16'h0700 | 16'(l * 2) | 16'(1 - l));
      repeat (3) @(posedge core_clk);
      #1 chk({14'h0000, pwm_out_a, pwm_out_b}, 16'(l + 1));
    end
    // Clock output on a with force off, b at zero duty
    wr(timer_pkg::OFS_FORCE, 16'h0100);
    wr(timer_pkg::OFS_PWM_DUTY, 16'h0000);
    repeat (600) @(posedge core_clk);
    count_high(ha, hb);
    chk(16'(ha), 16'h0200);
    chk(16'(hb), 16'h0000);
    // Compare-one clock output, then both counters on the external pin
    wr(timer_pkg::OFS_MASK, 16'h0008);
    repeat (8) @(posedge core_clk);
    ha = 0;
    repeat (1024) begin
      @(negedge core_clk);
      ha += compare_pins[0];
    end
    chk(16'(ha), 16'h0200);
    wr(timer_pkg::OFS_MASK, 16'h0007);
    wr(timer_pkg::OFS_FORCE, 16'h0070);
    rd(timer_pkg::OFS_MAIN_CNT, v);
    rd(timer_pkg::OFS_PWM_CNT, c);
    repeat (3) pin_partner_inst.pulse(5);
    rchk(timer_pkg::OFS_MAIN_CNT, v + 16'h0003);
    rchk(timer_pkg::OFS_PWM_CNT, c + 16'h0003);
    final_report();
  end
endmodule // test_timer_irq_flags_pwm_control

bind timer_irq_flags_pwm_control timer_ctl_checker timer_ctl_checker_inst (
  .core_clk, .nrst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
  .shared_pin_oe, .pwm_out_a, .pwm_out_b, .irq_req);
